// *** pkg/sfm_defines.svh ***
/*
 register offsets, field positions, reset values and timing for the fault manager.
 assumes a 250 MHz clock and a 32-bit AHB-Lite register bus.
*/
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH
`define SFM_OFF_CFG 8'h00
`define SFM_OFF_THR 8'h04
`define SFM_OFF_CLR 8'h08
`define SFM_OFF_STAT 8'h0c
`define SFM_CFG_RST 32'h0000000f
`define SFM_THR_RST 32'h00001000
`define SFM_CFG_EN_LSB 0
`define SFM_CFG_ACT_LSB 4
`define SFM_CFG_ENC_BIT 8
`define SFM_CFG_FW_BIT 9
`define SFM_CLR_BIT 0
`define SFM_NSAF 4
`define SFM_NCRIT 9
`define SFM_F_POS 0
`define SFM_F_NEG 1
`define SFM_F_PERR 2
`define SFM_F_SW 3
`define SFM_C_TEMP 0
`define SFM_TEMP_MAX_C 8'h4b
`define SFM_CLK_NS 4
`define SFM_BLINK_MS 250
`define SFM_BLINK_CYC (`SFM_BLINK_MS * 1000000 / `SFM_CLK_NS)
`endif

// *** pkg/sfm_pkg.sv ***
/*
 types shared by the fault manager files.
 assumes sfm_defines.svh is on the include path.
*/
`include "sfm_defines.svh"
package sfm_pkg;
  typedef struct packed {
    logic [31:0] thr;
    logic fw_mode;
    logic enc_present;
    logic [`SFM_NSAF-1:0] act_dis;
    logic [`SFM_NSAF-1:0] en;
  } sfm_cfg_t;
  typedef struct packed {
    logic rev_ok;
    logic fwd_ok;
    logic motor_on;
    logic [`SFM_NCRIT-1:0] crit;
    logic [`SFM_NSAF-1:0] saf;
  } sfm_stat_t;
  typedef enum logic [1:0] {SFM_LED_OFF, SFM_LED_ON, SFM_LED_BLINK, SFM_LED_ALT} sfm_led_t;
endpackage : sfm_pkg

// *** src/sfm_blink.sv ***
/*
 free-running blink phase generator.
 assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sfm_defines.svh"
module sfm_blink #(
  parameter int unsigned HALF_CYC = `SFM_BLINK_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic phase
);
  logic [31:0] cnt_q;
  logic phase_q;
  wire wrap = (cnt_q == 32'(HALF_CYC - 1));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 32'h0;
      phase_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1; // [RQ21]
      phase_q <= wrap ? ~phase_q : phase_q; // [RQ21]
    end
  end
  assign phase = phase_q;
endmodule : sfm_blink
`default_nettype wire

// *** src/sfm_ahb_slave.sv ***
/*
 AHB-Lite register slave of the fault manager: config, threshold, clear, status.
 assumes single word transfers, zero wait states, always OKAY.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sfm_defines.svh"
module sfm_ahb_slave (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire sfm_pkg::sfm_stat_t stat,
  output sfm_pkg::sfm_cfg_t cfg,
  output logic clr_pulse
);
  logic [31:0] cfg_q;
  logic [31:0] thr_q;
  logic [31:0] rdata_q;
  logic [7:0] waddr_q;
  logic wr_q;
  logic clr_q;
  //////////////////////////////////////////////////////////////////////////////
  // address phase decode and data phase write strobes
  wire take = hsel && htrans[1] && hready;
  wire [7:0] off = haddr[7:0];
  wire [31:0] stat_word = {{(32 - $bits(sfm_pkg::sfm_stat_t)){1'b0}}, stat};
  wire [31:0] rd_d = (off == `SFM_OFF_CFG) ? cfg_q :
                     (off == `SFM_OFF_THR) ? thr_q :
                     (off == `SFM_OFF_STAT) ? stat_word : 32'h0;
  wire wr_cfg = wr_q && (waddr_q == `SFM_OFF_CFG);
  wire wr_thr = wr_q && (waddr_q == `SFM_OFF_THR);
  wire wr_clr = wr_q && (waddr_q == `SFM_OFF_CLR) && hwdata[`SFM_CLR_BIT];
  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= `SFM_CFG_RST;
      thr_q <= `SFM_THR_RST;
      rdata_q <= 32'h0;
      waddr_q <= 8'h0;
      wr_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      wr_q <= take && hwrite;
      waddr_q <= take ? off : waddr_q;
      rdata_q <= (take && !hwrite) ? rd_d : rdata_q;
      cfg_q <= wr_cfg ? hwdata : cfg_q;
      thr_q <= wr_thr ? hwdata : thr_q;
      clr_q <= wr_clr; // [RQ6]
    end
  end
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign clr_pulse = clr_q;
  assign cfg.thr = thr_q;
  assign cfg.fw_mode = cfg_q[`SFM_CFG_FW_BIT];
  assign cfg.enc_present = cfg_q[`SFM_CFG_ENC_BIT];
  assign cfg.act_dis = cfg_q[`SFM_CFG_ACT_LSB +: `SFM_NSAF];
  assign cfg.en = cfg_q[`SFM_CFG_EN_LSB +: `SFM_NSAF];
endmodule : sfm_ahb_slave
`default_nettype wire

// *** src/sfm_top.sv ***
/*
 servo fault manager: fault latching and clearing, motion gating, status leds.
 assumes all inputs synchronous to clk; an AHB-Lite master reaches the registers.
*/
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "sfm_defines.svh"
// Overview of operation
// RQ1 - green dark unpowered, steady when powered
// RQ2 - red steady on any critical fault
// RQ3 - red blinks on any safety fault
// RQ4 - upgrade mode alternates green and red
// RQ5 - enable low-then-high requests fault clear
// RQ6 - software clear command acts like enable toggle
// RQ7 - blinking faults clear when condition goes
// RQ8 - safety action selectable; disable-motor faults latch
// RQ9 - critical fault disables motor at once
// RQ10 - critical clears only absent plus enable toggle
// RQ11 - positive limit blocks forward, clears on reverse
// RQ12 - negative limit blocks reverse, clears on forward
// RQ13 - position error above threshold raises fault
// RQ14 - stop-motion position error clears on move
// RQ15 - software stop input high raises fault
// RQ16 - software stop clears when low; blocks motion
// RQ17 - temperature above 75 C is critical
// RQ18 - eight other conditions are critical faults
// RQ19 - start pulses ignored while disabled or stopped
// RQ20 - critical indication wins over blinking
// RQ21 - blink rate fixed, even duty, from clock
module sfm_top #(
  parameter int unsigned BLINK_HALF_CYC = `SFM_BLINK_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic enable_in,
  input wire logic pos_limit_in,
  input wire logic neg_limit_in,
  input wire logic swstop_in,
  input wire logic start_in,
  input wire logic move_cmd_in,
  input wire logic moving_fwd_in,
  input wire logic moving_rev_in,
  input wire logic [31:0] enc_pos,
  input wire logic [31:0] cmd_pos,
  input wire logic [7:0] temp_c,
  input wire logic [`SFM_NCRIT-2:0] crit_in,
  output logic motor_en,
  output logic fwd_ok,
  output logic rev_ok,
  output logic start_ok,
  output logic led_green,
  output logic led_red
);
  sfm_pkg::sfm_cfg_t cfg;
  sfm_pkg::sfm_stat_t stat;
  sfm_pkg::sfm_led_t led_mode;
  logic sw_clr;
  logic blink_ph;
  logic en_q;
  logic [`SFM_NCRIT-1:0] crit_q;
  logic [`SFM_NSAF-1:0] saf_q;
  logic [`SFM_NSAF-1:0] saf_d;
  logic [`SFM_NSAF-1:0] saf_set;
  logic [`SFM_NSAF-1:0] saf_auto;
  logic motor_q;
  logic fwd_q;
  logic rev_q;
  logic start_q;
  logic green_q;
  logic red_q;
  logic green_d;
  logic red_d;
  //////////////////////////////////////////////////////////////////////////////
  // register slave and blink source
  sfm_ahb_slave u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .stat(stat),
    .cfg(cfg),
    .clr_pulse(sw_clr)
  );
  sfm_blink #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
    .clk(clk),
    .sys_rst(sys_rst),
    .phase(blink_ph)
  );
  //////////////////////////////////////////////////////////////////////////////
  // clear request and fault conditions
  wire en_rise = enable_in && !en_q; // [RQ5]
  wire clr_req = en_rise || sw_clr; // [RQ5] [RQ6]
  wire temp_hot = temp_c > `SFM_TEMP_MAX_C; // [RQ17]
  wire [`SFM_NCRIT-1:0] crit_cond = {crit_in, temp_hot}; // [RQ18]
  wire [`SFM_NCRIT-1:0] crit_d = crit_cond | (crit_q & ~{`SFM_NCRIT{clr_req}}); // [RQ10]
  wire [31:0] pos_diff = enc_pos - cmd_pos;
  wire [31:0] pos_mag = pos_diff[31] ? 32'h0 - pos_diff : pos_diff;
  wire perr_hit = cfg.enc_present && (pos_mag > cfg.thr); // [RQ13]
  assign saf_set[`SFM_F_POS] = pos_limit_in;
  assign saf_set[`SFM_F_NEG] = neg_limit_in;
  assign saf_set[`SFM_F_PERR] = perr_hit; // [RQ13]
  assign saf_set[`SFM_F_SW] = swstop_in; // [RQ15]
  assign saf_auto[`SFM_F_POS] = !pos_limit_in && moving_rev_in; // [RQ11]
  assign saf_auto[`SFM_F_NEG] = !neg_limit_in && moving_fwd_in; // [RQ12]
  assign saf_auto[`SFM_F_PERR] = move_cmd_in; // [RQ14]
  assign saf_auto[`SFM_F_SW] = !swstop_in; // [RQ16]
  //////////////////////////////////////////////////////////////////////////////
  // per-fault safety latch: set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < `SFM_NSAF; gi++) begin : g_saf
      wire set_i = cfg.en[gi] && saf_set[gi];
      wire clr_i = !cfg.en[gi] || (cfg.act_dis[gi] ? clr_req : saf_auto[gi]); // [RQ7] [RQ8]
      assign saf_d[gi] = set_i || (saf_q[gi] && !clr_i); // [RQ8]
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////////////
  // motion gating
  wire saf_dis = |(saf_d & cfg.act_dis);
  wire motor_d = enable_in && !(|crit_d) && !saf_dis; // [RQ9] [RQ10]
  wire stop_any = saf_d[`SFM_F_SW] || saf_d[`SFM_F_PERR]; // [RQ16]
  wire fwd_d = motor_d && !stop_any && !saf_d[`SFM_F_POS]; // [RQ11]
  wire rev_d = motor_d && !stop_any && !saf_d[`SFM_F_NEG]; // [RQ12]
  wire start_d = start_in && enable_in && !swstop_in && motor_d; // [RQ19]
  //////////////////////////////////////////////////////////////////////////////
  // led pattern selection
  assign led_mode = cfg.fw_mode ? sfm_pkg::SFM_LED_ALT :
                    (|crit_d) ? sfm_pkg::SFM_LED_ON :
                    (|saf_d) ? sfm_pkg::SFM_LED_BLINK : sfm_pkg::SFM_LED_OFF; // [RQ20]
  always_comb begin
    green_d = motor_d; // [RQ1]
    red_d = 1'b0;
    case (led_mode)
      sfm_pkg::SFM_LED_ALT: begin
        green_d = blink_ph; // [RQ4]
        red_d = !blink_ph; // [RQ4]
      end
      sfm_pkg::SFM_LED_ON: begin
        red_d = 1'b1; // [RQ2]
      end
      sfm_pkg::SFM_LED_BLINK: begin
        red_d = blink_ph; // [RQ3]
      end
      sfm_pkg::SFM_LED_OFF: begin
        red_d = 1'b0;
      end
      default: begin
        red_d = 1'b0;
      end
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // state and output flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_q <= 1'b1;
      crit_q <= '0;
      saf_q <= '0;
      motor_q <= 1'b0;
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
      start_q <= 1'b0;
      green_q <= 1'b0;
      red_q <= 1'b0;
    end else begin
      en_q <= enable_in;
      crit_q <= crit_d;
      saf_q <= saf_d;
      motor_q <= motor_d;
      fwd_q <= fwd_d;
      rev_q <= rev_d;
      start_q <= start_d;
      green_q <= green_d;
      red_q <= red_d;
    end
  end
  assign stat.rev_ok = rev_q;
  assign stat.fwd_ok = fwd_q;
  assign stat.motor_on = motor_q;
  assign stat.crit = crit_q;
  assign stat.saf = saf_q;
  assign motor_en = motor_q;
  assign fwd_ok = fwd_q;
  assign rev_ok = rev_q;
  assign start_ok = start_q;
  assign led_green = green_q;
  assign led_red = red_q;
  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_green;
    @(posedge clk) disable iff (sys_rst)
      !cfg.fw_mode |=> (led_green == motor_en);
  endproperty
  a_green: assert property (p_green) else $error("green led not motor power"); // [RQ1]
  property p_red_solid;
    @(posedge clk) disable iff (sys_rst)
      (!cfg.fw_mode && |crit_d) |=> led_red;
  endproperty
  a_red_solid: assert property (p_red_solid) else $error("red not solid on crit"); // [RQ2]
  property p_red_blink;
    @(posedge clk) disable iff (sys_rst)
      (!cfg.fw_mode && !(|crit_d) && |saf_d) |=> (led_red == $past(blink_ph));
  endproperty
  a_red_blink: assert property (p_red_blink) else $error("red not blinking"); // [RQ3]
  property p_fw_alt;
    @(posedge clk) disable iff (sys_rst)
      cfg.fw_mode |=> (led_green != led_red);
  endproperty
  a_fw_alt: assert property (p_fw_alt) else $error("upgrade leds not alternate"); // [RQ4]
  property p_crit_hold;
    @(posedge clk) disable iff (sys_rst)
      !clr_req |=> ((crit_q & $past(crit_q)) == $past(crit_q));
  endproperty
  a_crit_hold: assert property (p_crit_hold) else $error("crit lost w/o clear"); // [RQ10]
  property p_en_clr;
    @(posedge clk) disable iff (sys_rst)
      (!enable_in ##1 (enable_in && !(|crit_cond))) |=> (crit_q == '0);
  endproperty
  a_en_clr: assert property (p_en_clr) else $error("enable toggle did not clear"); // [RQ5]
  property p_sw_clr;
    @(posedge clk) disable iff (sys_rst)
      (sw_clr && !(|crit_cond)) |=> (crit_q == '0);
  endproperty
  a_sw_clr: assert property (p_sw_clr) else $error("software clear failed"); // [RQ6]
  property p_crit_off;
    @(posedge clk) disable iff (sys_rst)
      (|crit_cond || (|crit_q && !clr_req)) |=> !motor_en;
  endproperty
  a_crit_off: assert property (p_crit_off) else $error("motor on with crit"); // [RQ9]
  property p_temp;
    @(posedge clk) disable iff (sys_rst)
      (temp_c > `SFM_TEMP_MAX_C) |=> crit_q[`SFM_C_TEMP];
  endproperty
  a_temp: assert property (p_temp) else $error("over temp missed"); // [RQ17]
  property p_pos_lim;
    @(posedge clk) disable iff (sys_rst)
      saf_q[`SFM_F_POS] |-> !fwd_ok;
  endproperty
  a_pos_lim: assert property (p_pos_lim) else $error("forward at pos limit"); // [RQ11]
  property p_neg_lim;
    @(posedge clk) disable iff (sys_rst)
      saf_q[`SFM_F_NEG] |-> !rev_ok;
  endproperty
  a_neg_lim: assert property (p_neg_lim) else $error("reverse at neg limit"); // [RQ12]
  property p_sw_auto;
    @(posedge clk) disable iff (sys_rst)
      (!swstop_in && !cfg.act_dis[`SFM_F_SW]) |=> !saf_q[`SFM_F_SW];
  endproperty
  a_sw_auto: assert property (p_sw_auto) else $error("sw stop not auto cleared"); // [RQ16]
  property p_sw_set;
    @(posedge clk) disable iff (sys_rst)
      (swstop_in && cfg.en[`SFM_F_SW]) |=> (saf_q[`SFM_F_SW] && !fwd_ok && !rev_ok);
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("sw stop not raised"); // [RQ15]
  property p_start;
    @(posedge clk) disable iff (sys_rst)
      (!enable_in || swstop_in) |=> !start_ok;
  endproperty
  a_start: assert property (p_start) else $error("start taken while blocked"); // [RQ19]
  property p_perr;
    @(posedge clk) disable iff (sys_rst)
      (perr_hit && cfg.en[`SFM_F_PERR]) |=> saf_q[`SFM_F_PERR];
  endproperty
  a_perr: assert property (p_perr) else $error("position error missed"); // [RQ13]
  property p_pos_auto;
    @(posedge clk) disable iff (sys_rst)
      (!cfg.act_dis[`SFM_F_POS] && !pos_limit_in && moving_rev_in) |=> !saf_q[`SFM_F_POS];
  endproperty
  a_pos_auto: assert property (p_pos_auto) else $error("pos limit kept"); // [RQ11]
  property p_neg_auto;
    @(posedge clk) disable iff (sys_rst)
      (!cfg.act_dis[`SFM_F_NEG] && !neg_limit_in && moving_fwd_in) |=> !saf_q[`SFM_F_NEG];
  endproperty
  a_neg_auto: assert property (p_neg_auto) else $error("neg limit kept"); // [RQ12]
  property p_perr_move;
    @(posedge clk) disable iff (sys_rst)
      (!cfg.act_dis[`SFM_F_PERR] && move_cmd_in && !perr_hit) |=> !saf_q[`SFM_F_PERR];
  endproperty
  a_perr_move: assert property (p_perr_move) else $error("pos error kept"); // [RQ14]
  property p_saf_latch;
    @(posedge clk) disable iff (sys_rst)
      (saf_q[`SFM_F_POS] && cfg.act_dis[`SFM_F_POS] && cfg.en[`SFM_F_POS] && !clr_req)
        |=> saf_q[`SFM_F_POS];
  endproperty
  a_saf_latch: assert property (p_saf_latch) else $error("latched fault lost"); // [RQ8]
  property p_dis_motor;
    @(posedge clk) disable iff (sys_rst)
      (|(saf_d & cfg.act_dis)) |=> !motor_en;
  endproperty
  a_dis_motor: assert property (p_dis_motor) else $error("motor on with fault"); // [RQ8]
  property p_crit_motor;
    @(posedge clk) disable iff (sys_rst)
      (|crit_q) |-> !motor_en;
  endproperty
  a_crit_motor: assert property (p_crit_motor) else $error("motor on, crit held"); // [RQ10]
  property p_crit_set;
    @(posedge clk) disable iff (sys_rst)
      (|crit_cond) |=> ((crit_q & $past(crit_cond)) == $past(crit_cond));
  endproperty
  a_crit_set: assert property (p_crit_set) else $error("crit not latched"); // [RQ18]
  property p_sw_block;
    @(posedge clk) disable iff (sys_rst)
      saf_q[`SFM_F_SW] |-> (!fwd_ok && !rev_ok);
  endproperty
  a_sw_block: assert property (p_sw_block) else $error("motion in sw stop"); // [RQ16]
  property p_red_prio;
    @(posedge clk) disable iff (sys_rst)
      (!cfg.fw_mode && |crit_d && |saf_d) |=> led_red;
  endproperty
  a_red_prio: assert property (p_red_prio) else $error("red not solid"); // [RQ20]
  property p_green_alt;
    @(posedge clk) disable iff (sys_rst)
      cfg.fw_mode |=> (led_green == $past(blink_ph));
  endproperty
  a_green_alt: assert property (p_green_alt) else $error("green not blinking"); // [RQ4]
  property p_start_motor;
    @(posedge clk) disable iff (sys_rst)
      start_ok |-> motor_en;
  endproperty
  a_start_motor: assert property (p_start_motor) else $error("start, motor off"); // [RQ19]
  c_crit_clear: cover property (@(posedge clk) disable iff (sys_rst)
    (|crit_q) ##1 (crit_q == '0));
  c_pos_lim: cover property (@(posedge clk) disable iff (sys_rst)
    saf_q[`SFM_F_POS] ##1 !saf_q[`SFM_F_POS]);
  c_fw_mode: cover property (@(posedge clk) disable iff (sys_rst)
    cfg.fw_mode && led_green);
  c_start: cover property (@(posedge clk) disable iff (sys_rst) start_ok);
endmodule : sfm_top
`default_nettype wire

// *** verif/sfm_plc_model.sv ***
/*
 plc partner model: enable line, limit, stop, start, move and motion levels.
 assumes callers resume just after a rising edge of clk.
*/
`timescale 1ns/1ns
`default_nettype none
module sfm_plc_model (
  input wire logic clk,
  output logic enable_in,
  output logic pos_limit_in,
  output logic neg_limit_in,
  output logic swstop_in,
  output logic start_in,
  output logic move_cmd_in,
  output logic moving_fwd_in,
  output logic moving_rev_in
);
  logic [6:0] io_q = 7'h00;
  assign {pos_limit_in, neg_limit_in, swstop_in, start_in} = io_q[6:3];
  assign {move_cmd_in, moving_fwd_in, moving_rev_in} = io_q[2:0];
  initial enable_in = 1'b1;
  //////////////////////////////////////////////////////////////////////////////////////////
  // levels hold until the next call
  task automatic set_io(input logic [6:0] v);
    io_q <= v;
    @(posedge clk);
  endtask : set_io
  // low time chosen by caller: prompt or slow clear
  task automatic toggle_enable(input int low_cyc);
    enable_in <= 1'b0;
    repeat (low_cyc) @(posedge clk);
    enable_in <= 1'b1;
  endtask : toggle_enable
  task automatic set_en(input logic v);
    enable_in <= v;
    @(posedge clk);
  endtask : set_en
  // no edge wait: caller paces
  task automatic drive(input logic en, input logic [6:0] v);
    enable_in <= en;
    io_q <= v;
  endtask : drive
endmodule : sfm_plc_model
`default_nettype wire

// *** verif/servo_fault_manager_tb.sv ***
/*
 self-checking bench of sfm_top: registers, critical and safety faults, leds.
 assumes sfm_plc_model as the plc and a short blink half period.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sfm_defines.svh"
module servo_fault_manager_tb;
  localparam int unsigned HALF = 6;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, enc_pos = 32'h0, cmd_pos = 32'h0;
  logic [7:0] temp_c = 8'h19;
  logic [`SFM_NCRIT-2:0] crit_in = 8'h00;
  logic [31:0] rd, t;
  wire [31:0] hrdata;
  wire hreadyout, hresp, motor_en, fwd_ok, rev_ok, start_ok, led_green, led_red;
  wire enable_in, pos_limit_in, neg_limit_in, swstop_in;
  wire start_in, move_cmd_in, moving_fwd_in, moving_rev_in;
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 28;
  int i, n, m;
  logic en;
  logic m_en = 1'b1, m_mot, m_fwd, m_rev, m_st;
  logic [`SFM_NCRIT-1:0] m_crit = '0;
  logic [`SFM_NSAF-1:0] m_saf = '0;
  logic [`SFM_NCRIT-2:0] cr;
  logic [7:0] tp;
  logic [6:0] io;
  logic [31:0] cfgv, ep, cp;
  always #2 clk = ~clk;
  sfm_top #(.BLINK_HALF_CYC(HALF)) DUT (
    .clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .enable_in, .pos_limit_in,
    .neg_limit_in, .swstop_in, .start_in, .move_cmd_in, .moving_fwd_in, .moving_rev_in,
    .enc_pos, .cmd_pos, .temp_c, .crit_in, .motor_en, .fwd_ok, .rev_ok, .start_ok,
    .led_green, .led_red
  );
  sfm_plc_model PLC (
    .clk, .enable_in, .pos_limit_in, .neg_limit_in, .swstop_in, .start_in,
    .move_cmd_in, .moving_fwd_in, .moving_rev_in
  );
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic timeout(input string what);
    fail_count++;
    $display("mismatch %s expected done seen timeout", what);
    final_report();
  endtask : timeout
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task automatic bus_wait;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      if (hreadyout === 1'b1)
        return;
    end
    timeout("hready");
  endtask : bus_wait
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  // 0 dark, 1 steady, 2 blinking
  task automatic red_seen(input string what, input logic [31:0] exp);
    int ones;
    ones = 0;
    repeat (2 * HALF + 2) begin
      @(posedge clk);
      ones += (led_red === 1'b1);
    end
    chk(what, exp, ones == 0 ? 0 : (ones == 2 * HALF + 2 ? 1 : 2));
  endtask : red_seen
  // reference model, one clock edge
  task automatic model_step;
    logic clr;
    logic [31:0] d;
    logic [`SFM_NSAF-1:0] act, hit, aut;
    clr = en && !m_en;
    m_crit = {cr, tp > `SFM_TEMP_MAX_C} | (clr ? '0 : m_crit);
    d = ep - cp;
    d = d[31] ? 32'h0 - d : d;
    act = cfgv[7:4];
    hit = cfgv[3:0] & {io[4], cfgv[8] && d > t, io[5], io[6]};
    aut = {!io[4], io[2], !io[5] && io[1], !io[6] && io[0]};
    m_saf = hit | (m_saf & cfgv[3:0] & ~(act & {`SFM_NSAF{clr}}) & ~(~act & aut));
    m_mot = en && m_crit == '0 && (m_saf & act) == '0;
    m_fwd = m_mot && !m_saf[3] && !m_saf[2] && !m_saf[0];
    m_rev = m_mot && !m_saf[3] && !m_saf[2] && !m_saf[1];
    m_st = io[3] && en && !io[4] && m_mot;
    m_en = en;
  endtask : model_step
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    sys_rst <= 1'b0;
    cyc(4);
    bus(1'b0, `SFM_OFF_CFG, 32'h0);
    chk("cfg reset", `SFM_CFG_RST, rd);
    bus(1'b0, `SFM_OFF_THR, 32'h0);
    chk("thr reset", `SFM_THR_RST, rd);
    bus(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("green on", 32'h1, led_green);
    temp_c <= `SFM_TEMP_MAX_C;
    cyc(3);
    chk("motor at max temp", 32'h1, motor_en);
    for (i = 0; i < 9; i++) begin
      if (i == 0)
        temp_c <= 8'h4c | 8'($random(seed));
      else
        crit_in <= 8'h01 << (i - 1);
      cyc(2);
      bus(1'b0, `SFM_OFF_STAT, 32'h0);
      chk("crit stat", 32'h1 << (i + 4), rd & 32'h1ff0);
      chk("motor off", 32'h0, motor_en);
      chk("green off", 32'h0, led_green);
      red_seen("red solid", 32'h1);
      PLC.toggle_enable(2);
      cyc(3);
      chk("clear while present", 32'h0, motor_en);
      temp_c <= 8'h19;
      crit_in <= 8'h00;
      cyc(3);
      chk("no toggle yet", 32'h0, motor_en);
      if (i[0])
        bus(1'b1, `SFM_OFF_CLR, 32'h1);
      else
        PLC.toggle_enable(1 + i);
      cyc(3);
      chk("motor back", 32'h1, motor_en);
    end
    for (i = 0; i < 2; i++) begin
      PLC.set_io(i ? 7'h20 : 7'h40);
      cyc(2);
      chk("fwd at limit", i, fwd_ok);
      chk("rev at limit", !i, rev_ok);
      red_seen("red blink", 32'h2);
      PLC.set_io(7'h00);
      cyc(3);
      chk("no motion yet", i, fwd_ok);
      PLC.set_io(i ? 7'h02 : 7'h01);
      cyc(3);
      chk("limit cleared", 32'h1, fwd_ok & rev_ok);
      red_seen("red auto off", 32'h0);
      PLC.set_io(7'h00);
    end
    bus(1'b1, `SFM_OFF_CFG, 32'h1f);
    PLC.set_io(7'h40);
    cyc(2);
    chk("disable action", 32'h0, motor_en);
    PLC.set_io(7'h01);
    cyc(3);
    chk("disable latched", 32'h0, motor_en);
    bus(1'b1, `SFM_OFF_CLR, 32'h1);
    cyc(3);
    chk("sw clear", 32'h1, motor_en);
    PLC.set_io(7'h00);
    bus(1'b1, `SFM_OFF_CFG, `SFM_CFG_RST);
    PLC.set_io(7'h18);
    cyc(2);
    bus(1'b0, `SFM_OFF_STAT, 32'h0);
    chk("sw stop", 32'h8, rd & 32'hf);
    chk("start refused", 32'h0, start_ok);
    chk("fwd refused", 32'h0, fwd_ok);
    PLC.set_io(7'h08);
    cyc(3);
    chk("start taken", 32'h1, start_ok);
    PLC.set_en(1'b0);
    cyc(2);
    chk("start disabled", 32'h0, start_ok);
    PLC.set_en(1'b1);
    PLC.set_io(7'h00);
    t = 32'($random(seed)) & 32'hffff;
    bus(1'b1, `SFM_OFF_THR, t);
    bus(1'b0, `SFM_OFF_THR, 32'h0);
    chk("thr rw", t, rd);
    bus(1'b1, `SFM_OFF_CFG, 32'h10f);
    enc_pos <= 32'h100 + t;
    cmd_pos <= 32'h100;
    cyc(3);
    chk("err at thr", 32'h1, fwd_ok);
    enc_pos <= 32'h100;
    cmd_pos <= 32'h101 + t;
    cyc(3);
    chk("err above thr", 32'h0, fwd_ok);
    PLC.set_io(7'h04);
    PLC.set_io(7'h00);
    cyc(2);
    chk("move while err", 32'h0, fwd_ok);
    cmd_pos <= 32'h100;
    PLC.set_io(7'h04);
    PLC.set_io(7'h00);
    cyc(2);
    chk("err cleared", 32'h1, fwd_ok);
    bus(1'b1, `SFM_OFF_CFG, `SFM_CFG_RST);
    PLC.set_io(7'h10);
    crit_in <= 8'h80;
    cyc(2);
    red_seen("red priority", 32'h1);
    crit_in <= 8'h00;
    PLC.set_io(7'h00);
    bus(1'b1, `SFM_OFF_CLR, 32'h1);
    bus(1'b1, `SFM_OFF_CFG, 32'h20f);
    for (i = 0; i < 64 && led_green !== 1'b0; i++) @(posedge clk);
    for (i = 0; i < 64 && led_green !== 1'b1; i++) @(posedge clk);
    if (i == 64)
      timeout("blink");
    n = 0;
    for (i = 0; i < 64 && led_green === 1'b1; i++) begin
      n += (led_red === led_green);
      @(posedge clk);
    end
    for (m = 0; m < 64 && led_green === 1'b0; m++) @(posedge clk);
    chk("high half", HALF, i);
    chk("low half", HALF, m);
    chk("alternate", 32'h0, n);
    bus(1'b1, `SFM_OFF_CFG, `SFM_CFG_RST);
    cfgv = 32'($random(seed)) & 32'h1ff;
    bus(1'b1, {24'($random(seed)), `SFM_OFF_CFG}, cfgv);
    bus(1'b0, `SFM_OFF_CFG, 32'h0);
    chk("cfg rw", cfgv, rd);
    for (i = 0; i < 200; i++) begin
      en = ($random(seed) & 7) != 0;
      io = 7'($random(seed));
      cr = ($random(seed) & 15) == 0 ? 8'h1 << ($random(seed) & 7) : 8'h0;
      tp = 8'h45 + 8'($random(seed) & 7);
      ep = 32'($random(seed));
      cp = ep + t - 32'h1 + 32'($random(seed) & 3);
      PLC.drive(en, io);
      crit_in <= cr;
      temp_c <= tp;
      enc_pos <= ep;
      cmd_pos <= cp;
      model_step();
      @(posedge clk);
      @(negedge clk);
      chk("soak motor", m_mot, motor_en);
      chk("soak fwd", m_fwd, fwd_ok);
      chk("soak rev", m_rev, rev_ok);
      chk("soak start", m_st, start_ok);
      chk("soak green", m_mot, led_green);
      if (m_crit != '0 || m_saf == '0)
        chk("soak red", m_crit != '0, led_red);
      model_step();
      @(posedge clk);
    end
    final_report();
  end
endmodule : servo_fault_manager_tb
`default_nettype wire
